/* scs_pkg.sv */
`default_nettype none
package scs_pkg;
  // Register indices on the plain register port
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_TX_HOLD = 2'h2;
  localparam logic [1:0] ADDR_RX_HOLD = 2'h3;
  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h84;
  localparam logic [7:0] TX_HOLD_RST = 8'hFF;
  localparam logic [7:0] RX_HOLD_RST = 8'h00;
  // Control field positions
  localparam int CTL_TX_EMPTY_IRQ_EN = 7;
  localparam int CTL_RX_FULL_IRQ_EN = 6;
  localparam int CTL_TX_ENABLE = 5;
  localparam int CTL_RX_ENABLE = 4;
  localparam int CTL_ADDR_WAIT = 3;
  localparam int CTL_TX_DONE_IRQ_EN = 2;
  localparam int CTL_CLK_EXT = 1;
  localparam int CTL_CLK_PIN_OUT = 0;
  // Status field positions
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_RX_FULL = 6;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAMING = 4;
  localparam int ST_PARITY = 3;
  localparam int ST_TX_DONE = 2;
  localparam int ST_ADDR_RX = 1;
  localparam int ST_ADDR_TX = 0;
  // Prescaler select codes and divider masks
  localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
  localparam logic [1:0] PRESCALE_DIV16 = 2'h2;
  localparam logic [1:0] PRESCALE_DIV64 = 2'h3;
  localparam logic [5:0] MASK_DIV4 = 6'h03;
  localparam logic [5:0] MASK_DIV16 = 6'h0F;
  localparam logic [5:0] MASK_DIV64 = 6'h3F;
  // External clock in asynchronous mode runs at this multiple of the bit rate
  localparam int EXT_CLK_OVERSAMPLE = 16;
endpackage
`default_nettype wire

/* scs_serial_control_status.sv */
`timescale 1ns/1ps
`default_nettype none
module scs_serial_control_status
  import scs_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic low_power, // Standby or module stop entry
  input wire logic [1:0] reg_addr, // Register index
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic tc_tx_write, // Transfer controller writes holding reg
  input wire logic [7:0] tc_tx_data, // Transfer controller write data
  input wire logic tc_rx_read, // Transfer controller reads receive buffer
  input wire logic sync_mode, // Format: clocked synchronous mode
  input wire logic multiproc_format, // Format: multiprocessor format
  input wire logic parity_en, // Format: parity enable
  input wire logic parity_odd, // Format: odd parity
  input wire logic [1:0] prescale_sel, // Format: prescale_sel_hi, prescale_sel_lo
  input wire logic tx_shift_busy, // Shifter holds a character
  input wire logic tx_last_bit, // Pulse as final bit is sent
  input wire logic start_bit_seen, // Async start bit detected
  input wire logic sck_edge_seen, // Sync serial clock input detected
  input wire logic rx_frame_done, // Pulse at end of a received frame
  input wire logic [7:0] rx_shift_data, // Received character
  input wire logic rx_parity_bit, // Received parity bit
  input wire logic rx_stop_bit, // First stop bit value
  input wire logic rx_addr_bit, // Received multiprocessor bit
  input wire logic bit_clk, // Internal bit-rate clock level
  input wire logic sck_in, // Serial clock pin input
  output logic baud_tick, // Prescaled tick to the baud generator
  output logic tx_load, // Pulse: holding reg moves to shifter
  output logic [7:0] tx_load_data, // Data for the shifter
  output logic address_bit_to_send, // Multiprocessor bit to transmit
  output logic tx_halt, // Transmission stalled by receive error
  output logic rx_begin, // Pulse: start receiving a frame
  output logic ext_clk_sel, // Serial clock comes from the pin
  output logic ext_clk_div16, // External clock is 16x bit rate
  output logic sck_out, // Serial clock pin output value
  output logic sck_oe, // Serial clock pin output enable
  output logic tx_empty_irq, // Transmit empty request
  output logic rx_full_irq, // Receive full request
  output logic rx_error_irq, // Receive error request
  output logic tx_done_irq // Transmit done request
);

  logic [7:0] ctl_ff;
  logic [7:0] st_ff;
  logic [4:0] armed_ff;
  logic [7:0] tx_hold_ff;
  logic [7:0] rx_hold_ff;
  logic [5:0] pre_cnt_ff;

  // Register decode
  wire wr_ctl = reg_wr && (reg_addr == ADDR_CONTROL);
  wire wr_st = reg_wr && (reg_addr == ADDR_STATUS);
  wire wr_tdr = reg_wr && (reg_addr == ADDR_TX_HOLD);
  wire rd_st = reg_rd && (reg_addr == ADDR_STATUS);

  // Control fields
  wire tx_en = ctl_ff[CTL_TX_ENABLE];
  wire rx_en = ctl_ff[CTL_RX_ENABLE];
  wire async_mode = !sync_mode;
  wire wait_active = ctl_ff[CTL_ADDR_WAIT] && async_mode && multiproc_format;
  wire clk_ext = ctl_ff[CTL_CLK_EXT];
  wire tx_empty_en = ctl_ff[CTL_TX_EMPTY_IRQ_EN];
  wire rx_full_en = ctl_ff[CTL_RX_FULL_IRQ_EN];
  wire tx_done_en = ctl_ff[CTL_TX_DONE_IRQ_EN];

  // Status fields
  wire tx_buffer_empty = st_ff[ST_TX_EMPTY];
  wire rx_buffer_full = st_ff[ST_RX_FULL];
  wire overrun_flag = st_ff[ST_OVERRUN];
  wire framing_flag = st_ff[ST_FRAMING];
  wire parity_flag = st_ff[ST_PARITY];
  wire rx_err = overrun_flag | framing_flag | parity_flag;
  wire tx_complete = st_ff[ST_TX_DONE];

  // Flag clear: a 0 written to a bit that was read as 1
  wire [4:0] clr_sw = wr_st ? (armed_ff & ~reg_wdata[7:3]) : 5'h00;
  wire clr_tx_buffer_empty = clr_sw[4] || tc_tx_write;
  wire clr_rx_buffer_full = clr_sw[3] || tc_rx_read;

  // Hand-off to the shifter, stalled in sync mode by a receive error
  wire tx_stall = sync_mode && rx_err;
  wire do_load = tx_en && !tx_buffer_empty && !tx_shift_busy && !tx_stall;

  // Receive frame classification; a halted receiver ignores frames
  wire frame_ok = rx_frame_done && rx_en && !rx_err;
  wire frame_drop = frame_ok && wait_active && !rx_addr_bit;
  wire frame_use = frame_ok && !frame_drop;
  wire overrun = frame_use && rx_buffer_full;
  wire stop_bad = async_mode && !rx_stop_bit;
  wire par_calc = ^{rx_shift_data, rx_parity_bit};
  wire par_check = async_mode && parity_en && !multiproc_format;
  wire par_bad = par_check && (par_calc != parity_odd);
  wire store = frame_use && !rx_buffer_full;
  wire set_rx_buffer_full = store && !stop_bad && !par_bad;
  wire set_fer = store && stop_bad;
  wire set_per = store && par_bad;
  wire mp_update = frame_use && async_mode && multiproc_format;

  // Next status value; a hardware set wins over any clear
  logic [7:0] nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (!tx_en || do_load) begin
      nxt_st[ST_TX_EMPTY] = 1'b1;
    end else if (clr_tx_buffer_empty) begin
      nxt_st[ST_TX_EMPTY] = 1'b0;
    end
    if (set_rx_buffer_full) begin
      nxt_st[ST_RX_FULL] = 1'b1;
    end else if (clr_rx_buffer_full) begin
      nxt_st[ST_RX_FULL] = 1'b0;
    end
    if (overrun) begin
      nxt_st[ST_OVERRUN] = 1'b1;
    end else if (clr_sw[2]) begin
      nxt_st[ST_OVERRUN] = 1'b0;
    end
    if (set_fer) begin
      nxt_st[ST_FRAMING] = 1'b1;
    end else if (clr_sw[1]) begin
      nxt_st[ST_FRAMING] = 1'b0;
    end
    if (set_per) begin
      nxt_st[ST_PARITY] = 1'b1;
    end else if (clr_sw[0]) begin
      nxt_st[ST_PARITY] = 1'b0;
    end
    if (!tx_en || (tx_last_bit && tx_buffer_empty)) begin
      nxt_st[ST_TX_DONE] = 1'b1;
    end else if (clr_tx_buffer_empty) begin
      nxt_st[ST_TX_DONE] = 1'b0;
    end
    if (mp_update) begin
      nxt_st[ST_ADDR_RX] = rx_addr_bit;
    end
    if (wr_st) begin
      nxt_st[ST_ADDR_TX] = reg_wdata[ST_ADDR_TX];
    end
  end

  // Next control value; an address frame ends the wait by itself
  logic [7:0] nxt_ctl;
  always_comb begin
    nxt_ctl = wr_ctl ? reg_wdata : ctl_ff;
    if (frame_use && wait_active) begin
      nxt_ctl[CTL_ADDR_WAIT] = 1'b0;
    end
  end

  // Read-as-one tracking: a flag read as 0 cannot be cleared
  logic [4:0] nxt_armed;
  always_comb begin
    nxt_armed = armed_ff & nxt_st[7:3];
    if (wr_st) begin
      nxt_armed = 5'h00;
    end
    if (rd_st) begin
      nxt_armed = st_ff[7:3];
    end
  end

  // Read mux; status read shows the live flags
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      ADDR_CONTROL: rd_mux = ctl_ff;
      ADDR_STATUS: rd_mux = st_ff;
      ADDR_TX_HOLD: rd_mux = tx_hold_ff;
      ADDR_RX_HOLD: rd_mux = rx_hold_ff;
      default: rd_mux = 8'h00;
    endcase
  end

  // Prescaler tick selection
  logic tick_now;
  always_comb begin
    case (prescale_sel)
      PRESCALE_DIV1: tick_now = 1'b1;
      PRESCALE_DIV4: tick_now = (pre_cnt_ff & MASK_DIV4) == MASK_DIV4;
      PRESCALE_DIV16: tick_now = (pre_cnt_ff & MASK_DIV16) == MASK_DIV16;
      PRESCALE_DIV64: tick_now = (pre_cnt_ff & MASK_DIV64) == MASK_DIV64;
      default: tick_now = 1'b0;
    endcase
  end

  // Pin clock selection: sync mode ignores the pin-output bit
  wire pin_drives = !clk_ext && (sync_mode || ctl_ff[CTL_CLK_PIN_OUT]);
  wire nxt_sck = bit_clk; // both modes put the bit-rate clock itself on the pin

  // Reception may begin only while enabled and not halted by an error
  wire rx_trig = sync_mode ? sck_edge_seen : start_bit_seen;
  wire nxt_rx_begin = rx_en && !rx_err && rx_trig;

  // Next values of the pin and datapath outputs
  wire [7:0] nxt_load_data = do_load ? tx_hold_ff : tx_load_data;
  wire nxt_sck_out = pin_drives ? nxt_sck : sck_in;
  wire nxt_div16 = clk_ext && async_mode;

  // Request levels: flag and enable together, so dropping either withdraws it
  wire nxt_tx_empty_irq = tx_empty_en && tx_buffer_empty;
  wire nxt_rx_full_irq = rx_full_en && rx_buffer_full;
  wire nxt_rx_error_irq = rx_full_en && rx_err;
  wire nxt_tx_done_irq = tx_done_en && tx_complete;

  // Control register; low power acts like reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_ff <= CONTROL_RST;
    end else if (low_power) begin
      ctl_ff <= CONTROL_RST;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  // Status flags; low power reloads them like reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= STATUS_RST;
    end else if (low_power) begin
      st_ff <= STATUS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Read-as-one marks; dropped with the flags so an old read cannot clear a new flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_ff <= 5'h00;
    end else if (low_power) begin
      armed_ff <= 5'h00;
    end else begin
      armed_ff <= nxt_armed;
    end
  end

  // Transmit holding register; a CPU write never clears the empty flag itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_hold_ff <= TX_HOLD_RST;
    end else if (low_power) begin
      tx_hold_ff <= TX_HOLD_RST;
    end else if (tc_tx_write) begin
      tx_hold_ff <= tc_tx_data;
    end else if (wr_tdr) begin
      tx_hold_ff <= reg_wdata;
    end
  end

  // Receive buffer; frames with a bad stop or parity bit still land here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_hold_ff <= RX_HOLD_RST;
    end else if (low_power) begin
      rx_hold_ff <= RX_HOLD_RST;
    end else if (store) begin
      rx_hold_ff <= rx_shift_data;
    end
  end

  // Prescaler counter free runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt_ff <= 6'h00;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 6'h01;
    end
  end

  // Read data stands for one cycle only, then drops back to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Transmit side outputs; the shifter sees a new byte only with the load pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_tick <= 1'b0;
      tx_load <= 1'b0;
      tx_load_data <= TX_HOLD_RST;
      address_bit_to_send <= 1'b0;
      tx_halt <= 1'b0;
    end else begin
      baud_tick <= tick_now;
      tx_load <= do_load;
      tx_load_data <= nxt_load_data;
      address_bit_to_send <= st_ff[ST_ADDR_TX];
      tx_halt <= tx_stall;
    end
  end

  // Receive start and serial clock pin outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_begin <= 1'b0;
      ext_clk_sel <= 1'b0;
      ext_clk_div16 <= 1'b0;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
    end else begin
      rx_begin <= nxt_rx_begin;
      ext_clk_sel <= clk_ext;
      ext_clk_div16 <= nxt_div16;
      sck_out <= nxt_sck_out;
      sck_oe <= pin_drives;
    end
  end

  // Interrupt requests, one cycle behind flag and enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_empty_irq <= 1'b0;
      rx_full_irq <= 1'b0;
      rx_error_irq <= 1'b0;
      tx_done_irq <= 1'b0;
    end else begin
      tx_empty_irq <= nxt_tx_empty_irq;
      rx_full_irq <= nxt_rx_full_irq;
      rx_error_irq <= nxt_rx_error_irq;
      tx_done_irq <= nxt_tx_done_irq;
    end
  end

  // Clearing rx_enable touches no receive flag: only frames set them
  // Format and mode must be set by software before enables
  // Limits that a user of this block should know:
  // The prescaler free runs, so the first tick after a code change may come early
  // A CPU read of the receive buffer leaves rx_buffer_full alone
  // Only a flag clear, the transfer controller read or low power drops rx_buffer_full
  // A controller write and a CPU write in one cycle: the controller data wins
  // Sync mode ignores the pin-output bit; the internal clock goes out unless the external clock bit is set
  // Framing and parity may both set on one frame; each clears on its own
  // Any status write drops every read mark, so read again before the next clear
  // Low power leaves the prescaler and the output registers running

endmodule
`default_nettype wire

/* scs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module scs_chk
  import scs_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic low_power, // Low power
  input wire logic [1:0] reg_addr, // Index
  input wire logic [7:0] reg_wdata, // Data
  input wire logic reg_wr, // Write
  input wire logic [1:0] prescale_sel, // Prescale
  input wire logic baud_tick, // Tick
  input wire logic tx_load, // Load
  input wire logic tx_shift_busy, // Busy
  input wire logic start_bit_seen, // Start
  input wire logic sck_edge_seen, // Clock edge
  input wire logic rx_begin, // Rx begin
  input wire logic ext_clk_sel, // Ext clock
  input wire logic sck_oe, // Pin enable
  input wire logic tx_empty_irq, // Irq
  input wire logic rx_full_irq, // Irq
  input wire logic rx_error_irq, // Irq
  input wire logic tx_done_irq // Irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Control writes, then the register feeds the requests a cycle later
  sequence ctl_wr_s;
    reg_wr && reg_addr == ADDR_CONTROL;
  endsequence
  sequence gap4_s;
    (!baud_tick)[*3] ##1 baud_tick;
  endsequence
  div1_tick_a: assert property ((prescale_sel == PRESCALE_DIV1)[*3] |-> baud_tick)
    else $error("tick missing at divide by one");
  div4_gap_a: assert property ((prescale_sel == PRESCALE_DIV4)[*8] ##0 baud_tick |=> gap4_s)
    else $error("divide by four spacing wrong");
  rx_start_a: assert property (rx_begin |-> $past(start_bit_seen || sck_edge_seen))
    else $error("receive began without a trigger");
  tx_start_a: assert property (tx_load |-> !$past(tx_shift_busy))
    else $error("load while shifter busy");
  pin_dir_a: assert property (ext_clk_sel |-> !sck_oe)
    else $error("pin driven while clock is an input");
  irq_off_a: assert property (ctl_wr_s ##0 reg_wdata == 8'h00 |-> ##2
    !(tx_empty_irq || rx_full_irq || rx_error_irq || tx_done_irq))
    else $error("request stays after enables cleared");
  te_off_irq_a: assert property (ctl_wr_s ##0 reg_wdata[7] && !reg_wdata[5] |->
    ##[2:3] tx_empty_irq)
    else $error("empty request missing with transmit off");
  lp_clear_a: assert property (low_power[*2] |=> !(tx_empty_irq || tx_done_irq))
    else $error("request survives low power");
endmodule
bind scs_serial_control_status scs_chk u_chk (.*);
`default_nettype wire

/* scs_station.sv */
`timescale 1ns/1ps
`default_nettype none
module scs_station (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic go, // Send a frame
  input wire logic [10:0] frm, // Addr, stop, parity, data
  input wire logic tx_load, // Shifter load
  output logic start_bit_seen, // Start seen
  output logic rx_frame_done, // Frame end
  output logic [7:0] rx_shift_data, // Data
  output logic rx_parity_bit, // Parity
  output logic rx_stop_bit, // Stop
  output logic rx_addr_bit, // Address bit
  output logic tx_shift_busy, // Shifting
  output logic tx_last_bit // Final bit
);
  logic [3:0] rc_ff;
  logic [3:0] tc_ff;
  logic [10:0] f_ff;
  // Frame and character timers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rc_ff <= 4'h0;
      tc_ff <= 4'h0;
      f_ff <= 11'h000;
    end else begin
      rc_ff <= go ? 4'h8 : rc_ff - 4'(rc_ff != 4'h0);
      tc_ff <= tx_load ? 4'hA : tc_ff - 4'(tc_ff != 4'h0);
      f_ff <= go ? frm : f_ff;
    end
  end
  assign start_bit_seen = rc_ff == 4'h8; // Start always leads the frame
  assign rx_frame_done = rc_ff == 4'h1;
  // Idle lines carry the inverse so stale data cannot pass
  assign {rx_addr_bit, rx_stop_bit, rx_parity_bit, rx_shift_data} = rx_frame_done ? f_ff : ~f_ff;
  assign tx_shift_busy = tc_ff != 4'h0;
  assign tx_last_bit = tc_ff == 4'h1;
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic low_power = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sync_mode = 1'b0;
  logic multiproc_format = 1'b0;
  logic parity_en = 1'b0;
  logic parity_odd = 1'b0;
  logic [1:0] prescale_sel = 2'h0;
  logic bit_clk = 1'b0;
  logic go = 1'b0;
  logic [10:0] frm = 11'h000;
  logic tc_tx_write = 1'b0;
  logic [7:0] tc_tx_data = 8'h00;
  logic tc_rx_read = 1'b0;
  logic sck_edge_seen = 1'b0;
  logic sck_in = 1'b0;
  logic [7:0] reg_rdata, rx_shift_data, tx_load_data, n_begin, nb;
  logic start_bit_seen, rx_frame_done, rx_parity_bit, rx_stop_bit, rx_addr_bit;
  logic tx_shift_busy, tx_last_bit, baud_tick, tx_load, address_bit_to_send, tx_halt;
  logic rx_begin, ext_clk_sel, ext_clk_div16, sck_out, sck_oe;
  logic tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  scs_serial_control_status DUT (.*);
  scs_station u_sta (.*);
  always #2.5 clk = ~clk;
  // Slow bit clock, receive starts and a hang limit
  always @(posedge clk) begin
    bit_clk <= ~bit_clk;
    n_begin <= rst ? 8'h00 : n_begin + 8'(rx_begin);
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task stop_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rc(input logic [1:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(n, reg_rdata, e);
  endtask
  // One frame from the far station, then time to settle
  task send(input logic [10:0] f);
    nb = n_begin;
    @(posedge clk);
    frm <= f;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task s_regs();
    rc(ADDR_CONTROL, CONTROL_RST, "control");
    rc(ADDR_STATUS, STATUS_RST, "status");
    wr(ADDR_STATUS, 8'hFF);
    rc(ADDR_STATUS, 8'h85, "status ones");
    wr(ADDR_CONTROL, 8'h0A);
    rc(ADDR_CONTROL, 8'h0A, "control rw");
    @(posedge clk);
    low_power <= 1'b1;
    repeat (2) @(posedge clk);
    low_power <= 1'b0;
    rc(ADDR_CONTROL, CONTROL_RST, "control lp");
    rc(ADDR_STATUS, STATUS_RST, "status lp");
  endtask
  task s_tx();
    int i;
    wr(ADDR_CONTROL, 8'h84);
    repeat (3) @(negedge clk);
    chk("tx irqs", {6'h0, tx_empty_irq, tx_done_irq}, 8'h03);
    wr(ADDR_CONTROL, 8'hA0);
    wr(ADDR_TX_HOLD, 8'h5A);
    rc(ADDR_STATUS, 8'h84, "status tx");
    wr(ADDR_STATUS, 8'h7F);
    i = 0;
    while (tx_load !== 1'b1 && i < 8) begin
      @(negedge clk);
      i++;
    end
    chk("load data", tx_load_data, 8'h5A);
    chk("addr bit", {7'h0, address_bit_to_send}, 8'h01);
    rc(ADDR_STATUS, 8'h81, "status load");
    chk("empty irq", {7'h0, tx_empty_irq}, 8'h01);
    repeat (12) @(posedge clk);
    rc(ADDR_STATUS, 8'h85, "status end");
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_STATUS, 8'h00);
    repeat (3) @(negedge clk);
    chk("irqs off", {6'h0, tx_empty_irq, tx_done_irq}, 8'h00);
  endtask
  task s_rx();
    wr(ADDR_CONTROL, 8'h50);
    send(11'h23C);
    chk("begin", n_begin, nb + 8'h01);
    chk("rx irqs", {6'h0, rx_full_irq, rx_error_irq}, 8'h02);
    rc(ADDR_STATUS, 8'hC4, "full");
    send(11'h2A5);
    chk("rx irqs or", {6'h0, rx_full_irq, rx_error_irq}, 8'h03);
    rc(ADDR_RX_HOLD, 8'h3C, "kept");
    wr(ADDR_CONTROL, 8'h40);
    rc(ADDR_STATUS, 8'hE4, "overrun");
    wr(ADDR_STATUS, 8'h00);
    rc(ADDR_STATUS, 8'h84, "cleared");
    chk("rx irqs off", {6'h0, rx_full_irq, rx_error_irq}, 8'h00);
  endtask
  task s_err();
    wr(ADDR_CONTROL, 8'h50);
    send(11'h011);
    rc(ADDR_STATUS, 8'h94, "framing");
    rc(ADDR_RX_HOLD, 8'h11, "framing data");
    send(11'h23C);
    chk("halt framing", n_begin, nb);
    wr(ADDR_STATUS, 8'h00);
    @(posedge clk);
    parity_en <= 1'b1;
    send(11'h201);
    rc(ADDR_STATUS, 8'h8C, "parity");
    rc(ADDR_RX_HOLD, 8'h01, "parity data");
    send(11'h23C);
    chk("halt parity", n_begin, nb);
    wr(ADDR_STATUS, 8'h00);
    @(posedge clk);
    parity_odd <= 1'b1;
    send(11'h201);
    rc(ADDR_STATUS, 8'hC4, "odd ok");
    wr(ADDR_STATUS, 8'h00);
    @(posedge clk);
    parity_en <= 1'b0;
  endtask
  task s_mpw();
    @(posedge clk);
    multiproc_format <= 1'b1;
    wr(ADDR_CONTROL, 8'h58);
    send(11'h277);
    rc(ADDR_STATUS, 8'h84, "skipped");
    send(11'h642);
    rc(ADDR_STATUS, 8'hC6, "addr frame");
    rc(ADDR_CONTROL, 8'h50, "wait off");
    rc(ADDR_RX_HOLD, 8'h42, "addr data");
  endtask
  // Transfer controller access, sync receive start and the sync halt
  task s_tc();
    @(posedge clk);
    tc_rx_read <= 1'b1;
    @(posedge clk);
    tc_rx_read <= 1'b0;
    rc(ADDR_STATUS, 8'h86, "tc read");
    wr(ADDR_CONTROL, 8'hA0);
    @(posedge clk);
    tc_tx_write <= 1'b1;
    tc_tx_data <= 8'hC3;
    @(posedge clk);
    tc_tx_write <= 1'b0;
    repeat (2) @(negedge clk);
    chk("tc load", {7'h0, tx_load}, 8'h01);
    chk("tc data", tx_load_data, 8'hC3);
    rc(ADDR_STATUS, 8'h82, "tc status");
    wr(ADDR_CONTROL, 8'h10);
    send(11'h011);
    @(posedge clk);
    sync_mode <= 1'b1;
    sck_edge_seen <= 1'b1;
    nb = n_begin;
    @(posedge clk);
    sck_edge_seen <= 1'b0;
    repeat (3) @(posedge clk);
    chk("halt sync", n_begin, nb);
    chk("tx halt", {7'h0, tx_halt}, 8'h01);
    rc(ADDR_STATUS, 8'h94, "sync err");
    wr(ADDR_STATUS, 8'h00);
    nb = n_begin;
    @(posedge clk);
    sck_edge_seen <= 1'b1;
    @(posedge clk);
    sck_edge_seen <= 1'b0;
    repeat (3) @(posedge clk);
    chk("sync begin", n_begin, nb + 8'h01);
    chk("tx run", {7'h0, tx_halt}, 8'h00);
    @(posedge clk);
    sync_mode <= 1'b0;
  endtask
  task s_pre();
    int c;
    logic [7:0] n;
    for (int i = 0; i < 4; i++) begin
      c = {i[0] ^ i[1], i[1]};
      @(posedge clk);
      prescale_sel <= 2'(c);
      repeat (70) @(negedge clk);
      n = 8'h00;
      repeat (64) begin
        @(negedge clk);
        n = n + 8'(baud_tick);
      end
      chk("ticks", n, 8'(64 >> (2 * c)));
    end
  endtask
  task s_pin();
    logic [2:0] m;
    logic p;
    for (int j = 0; j < 8; j++) begin
      m = 3'(j);
      p = m[2] ? !m[1] : (!m[1] & m[0]);
      @(posedge clk);
      sync_mode <= m[2];
      sck_in <= m[0];
      wr(ADDR_CONTROL, {6'h0, m[1:0]});
      repeat (3) @(negedge clk);
      chk("pin", {5'h0, ext_clk_div16, ext_clk_sel, sck_oe},
        {5'h0, m[1] & !m[2], m[1], p});
      chk("sck", {7'h0, sck_out}, {7'h0, p ? !bit_clk : m[0]});
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    s_regs();
    s_tx();
    s_rx();
    s_err();
    s_mpw();
    s_tc();
    s_pin();
    s_pre();
    stop_test();
  end
endmodule
`default_nettype wire
